// *** tb/ac_link_ctrl_codec_model.sv ***
// Purpose: Behavioural codec on one serial input of the AC-link
// Assumes: Frames start at the first bit clock edge after reset release
// Notes:   Answers a command in the frame after the one that carried it
`timescale 1ns/100ps
`default_nettype none
module ac_link_ctrl_codec_model #(
  parameter logic [1:0] ID        = 2'h0,
  parameter bit         PRIMARY   = 1'b1,
  parameter int         START_DLY = 200
) (
  input  wire logic        rst_n_i,
  input  wire logic        bclk_i,
  input  wire logic        sync_i,
  input  wire logic        sdo_i,
  input  wire logic        ready_i,
  output logic             bclk_o,
  output logic             sdi_o,
  output logic      [19:0] s3_o,
  output logic             s3_valid_o
);
  logic [15:0]  regs [128];
  logic [255:0] frm;
  logic [255:0] rx;
  logic [6:0]   a;
  int           pos;
  bit           run;

  // Clock stands still in reset and well past its release
  initial
  begin
    bclk_o = 1'b0;
    if (PRIMARY) forever
    begin
      wait (rst_n_i === 1'b1);
      #(START_DLY);
      while (rst_n_i === 1'b1)
      begin
        #24 bclk_o = 1'b1;
        #24 bclk_o = 1'b0;
      end
    end
  end

  always @(posedge bclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run = 1'b0;
      pos = 0;
      rx = '0;
      frm = '0;
      sdi_o = 1'b0;
    end
    else
    begin
      pos = run ? (pos + 1) % 256 : 0;
      run = 1'b1;
      if (pos == 0)
      begin
        // Zero slot-request bits ask for every output slot
        frm = '0;
        frm[255] = ready_i;
        // Primary codec streams a fixed record pair and a mic sample
        if (PRIMARY)
        begin
          frm[252:251] = 2'b11;
          frm[249] = 1'b1;
          frm[199:184] = 16'h1357;
          frm[179:164] = 16'h2468;
          frm[139:124] = 16'h0abc;
        end
        s3_o = rx[199:180];
        s3_valid_o = rx[252];
        a = rx[238:232];
        if (rx[241:240] == ID && (ID != 2'h0 || rx[254]))
        begin
          if (rx[239])
          begin
            frm[254:253] = 2'b11;
            frm[238:232] = a;
            frm[219:204] = regs[a];
          end
          else
            regs[a] = rx[219:204];
        end
      end
      sdi_o = frm[255-pos];
    end
  end

  always @(negedge bclk_i)
  begin
    if (run)
      rx[255-pos] = sdo_i;
  end
endmodule
`default_nettype wire

// *** tb/tb_ac_link_ctrl_ac_link_ctrl.sv ***
// Purpose: Self-checking bench for the AC-link controller
// Assumes: Two codec models, IDs 0 and 3, on the two serial inputs
// Notes:   Register expectations follow the hand-over register map
`timescale 1ns/100ps
`default_nettype none
module tb_ac_link_ctrl_ac_link_ctrl;
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } ac_link_ctrl_row_s;
  ac_link_ctrl_row_s   rows [8];
  logic        clk_i, rst_i, cyc, stb, we, ack, bclk, sync, sdo, lrn, irq, s3v;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dout;
  logic [1:0]  rdy, id;
  wire [1:0]   sdi;
  logic [6:0]  dma, rdma;
  logic [19:0] s3, v;
  int          n_fail, checked, i, n;

  ac_link_ctrl_ac_link_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout),
    .wb_ack_o(ack), .bit_clk_i(bclk), .sdata_in_i(sdi), .sync_o(sync),
    .sdata_out_o(sdo), .link_reset_n_o(lrn), .dma_req_o(dma), .irq_o(irq));
  ac_link_ctrl_codec_model #(.ID(2'h0), .PRIMARY(1'b1)) codec0 (.rst_n_i(lrn), .bclk_i(bclk),
    .sync_i(sync), .sdo_i(sdo), .ready_i(rdy[0]), .bclk_o(bclk), .sdi_o(sdi[0]),
    .s3_o(s3), .s3_valid_o(s3v));
  ac_link_ctrl_codec_model #(.ID(2'h3), .PRIMARY(1'b0)) codec1 (.rst_n_i(lrn), .bclk_i(bclk),
    .sync_i(sync), .sdo_i(sdo), .ready_i(rdy[1]), .bclk_o(), .sdi_o(sdi[1]),
    .s3_o(), .s3_valid_o());

  task automatic give_verdict;
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    k = 0;
    // Ack is sampled at the rising edge; data is taken and the request dropped there
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 100);
    if (ack !== 1'b1)
    begin
      chk(0, 1, "bus timeout");
      give_verdict();
    end
    rdat = dout;
    rdma = dma;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_sts(input logic [31:0] m);
    int k;
    k = 0;
    do
    begin
      wb(1'b0, ac_link_ctrl_pkg::OFF_STS, 4'hf, 32'h0);
      k++;
    end
    while ((rdat & m) !== m && k < 8000);
    if ((rdat & m) !== m)
    begin
      chk(0, 1, "status timeout");
      give_verdict();
    end
  endtask

  // Returns the first valid slot 3 word seen over about three frames
  task automatic watch_s3(output logic [19:0] f);
    f = 20'h0;
    repeat (8000)
    begin
      @(negedge clk_i);
      if (s3v === 1'b1 && f === 20'h0)
        f = s3;
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial
  begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    rdy = 2'b00;
    n_fail = 0;
    checked = 0;
    rows = '{'{1'b0, ac_link_ctrl_pkg::OFF_CTL, 32'h0, ac_link_ctrl_pkg::CTL_RST},
             '{1'b0, ac_link_ctrl_pkg::OFF_SLT, 32'h0, 32'h0},
             '{1'b0, ac_link_ctrl_pkg::OFF_STS, 32'h0, 32'h0},
             '{1'b1, ac_link_ctrl_pkg::OFF_MSK, 32'h3, 32'h0},
             '{1'b0, ac_link_ctrl_pkg::OFF_MSK, 32'h0, 32'h3},
             '{1'b1, 8'h1c, 32'hffff_ffff, 32'h0},
             '{1'b0, 8'h1c, 32'h0, 32'h0},
             '{1'b0, ac_link_ctrl_pkg::OFF_DAT, 32'h0, 32'h0}};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, lrn}, 32'h0, "codec reset not held");
    chk({25'h0, dma}, 32'h0, "dma request after reset");
    for (i = 0; i < 8; i++)
    begin
      wb(rows[i].we, rows[i].a, 4'hf, rows[i].d);
      if (!rows[i].we) chk(rdat, rows[i].e, "register readback");
    end
    // Codec reset stays asserted for a full microsecond
    repeat (200) @(posedge clk_i);
    wb(1'b1, ac_link_ctrl_pkg::OFF_CTL, 4'hf, 32'h0001_0001);
    @(negedge clk_i);
    chk({31'h0, lrn}, 32'h1, "link reset not released");
    chk({25'h0, dma}, 32'h1, "dma enable gating");
    n = 0;
    while (sync !== 1'b1 && n < 4000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, sync}, 32'h1, "no frame sync");
    if (sync !== 1'b1)
      give_verdict();
    n = 0;
    while (sync === 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    chk({31'h0, n > 149 && n < 159}, 32'h1, "sync width");
    rdy <= 2'b11;
    wait_sts(32'h3);
    chk({31'h0, irq}, 32'h1, "ready interrupt");
    for (i = 0; i < 2; i++)
    begin
      id = (i == 0) ? 2'h0 : 2'h3;
      wb(1'b1, ac_link_ctrl_pkg::OFF_ACC, 4'hf, {6'h0, id, 1'b0, 7'h02, 16'h1234 + 16'(i)});
      wait_sts(32'h4);
      wb(1'b1, ac_link_ctrl_pkg::OFF_STS, 4'hf, 32'h4);
      wb(1'b1, ac_link_ctrl_pkg::OFF_ACC, 4'hf, {1'b1, 5'h0, id, 1'b0, 7'h02, 16'h0});
      wait_sts(32'h4);
      wb(1'b0, ac_link_ctrl_pkg::OFF_ACC, 4'hf, 32'h0);
      chk({16'h0, rdat[15:0]}, {16'h0, 16'h1234 + 16'(i)}, "codec read data");
      wb(1'b1, ac_link_ctrl_pkg::OFF_STS, 4'hf, 32'h4);
    end
    // A part-word write must not reach the FIFO
    wb(1'b1, ac_link_ctrl_pkg::OFF_DAT, 4'h3, 32'hdead_beef);
    wb(1'b1, ac_link_ctrl_pkg::OFF_DAT, 4'hf, 32'h5678_1234);
    chk({31'h0, rdma[0]}, 32'h0, "dma request not dropped");
    watch_s3(v);
    chk({12'h0, v}, 32'h0, "slot sent while disabled");
    wb(1'b1, ac_link_ctrl_pkg::OFF_SLT, 4'hf, 32'h1);
    watch_s3(v);
    chk({12'h0, v}, 32'h0001_2340, "slot 3 sample");
    // Record path: PCM pair first, then the mic slot
    wb(1'b1, ac_link_ctrl_pkg::OFF_SLT, 4'hf, 32'h11);
    watch_s3(v);
    wb(1'b0, 8'h30, 4'hf, 32'h0);
    chk(rdat, 32'h2468_1357, "pcm record word");
    wb(1'b1, ac_link_ctrl_pkg::OFF_CTL, 4'hf, 32'h0003_0011);
    wb(1'b0, 8'h30, 4'hf, 32'h0);
    wb(1'b0, 8'h30, 4'hf, 32'h0);
    watch_s3(v);
    wb(1'b0, 8'h30, 4'hf, 32'h0);
    chk(rdat, 32'h0000_0abc, "mic record word");
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/ac_link_ctrl_ac_link_ctrl.sv ***
// Purpose: AC-link controller with Wishbone registers, frame engine and stream FIFOs
// Assumes: bit_clk_i is far slower than clk_i; codecs drive unused slots low
// Notes:   Both serial inputs are merged by OR for slot data
// Overview of operation
// - Link enable bit drives link reset, default 0
// - Running bit clock starts sync and framing
// - Tag codec-ready sets per-input ready status
// - Ready events seen by polling or interrupt
// - Two serial inputs, at most two codecs
// - Finished codec access sets access-ready status
// - Read flag one starts codec register read
// - Read flag zero starts codec register write
// - Send valid-tagged slots, capture incoming slots
// - Slot-enable bit gates each stream
// - Separate FIFO per stream; DMA fills playback FIFOs, empties record FIFOs
// - Control-enable bit gates each DMA request
// - Samples are 16 bits wide
// - Record source is PCM pair or mic
// - Sample in upper 16 bits; word access only
// - DMA request drops on data register access
`timescale 1ns/100ps
`default_nettype none
module ac_link_ctrl_ac_link_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        bit_clk_i,
  input  wire logic [1:0]  sdata_in_i,
  output logic             sync_o,
  output logic             sdata_out_o,
  output logic             link_reset_n_o,
  output logic      [6:0]  dma_req_o,
  output logic             irq_o
);
  typedef struct packed {
    logic [31:0]         ctl;
    logic [6:0]          slt;
    logic [2:0]          sts;
    logic [2:0]          msk;
    logic                irq;
    logic                acc_rd;
    logic [1:0]          acc_id;
    logic [6:0]          acc_addr;
    logic [15:0]         acc_wdat;
    logic [15:0]         acc_rdat;
    ac_link_ctrl_pkg::ac_link_ctrl_acc_e ast;
    logic                cmd_frm;
    logic                bck;
    logic [3:0]          slot;
    logic [4:0]          pos;
    logic                sync;
    logic                sdo;
    logic [19:0]         txsh;
    logic [19:0]         rxsh;
    logic [15:0]         tagv;
    logic [12:3]         sreq;
    logic                st_ok;
    logic [6:0]          act;
    logic [6:0]          half;
    logic [1:0][15:0]    hold;
    logic                ack;
    logic [31:0]         rdat;
    logic [6:0]          dreq;
  } ac_link_ctrl_state_s;

  ac_link_ctrl_state_s      q;
  ac_link_ctrl_state_s      d;
  logic [2:0]       pin_s;
  logic [6:0]       push;
  logic [6:0]       pop;
  logic [6:0]       empty;
  logic [6:0]       full;
  logic [6:0]       acc_hit;
  logic [6:0][31:0] fdout;
  logic [31:0]      rx_word;
  logic [19:0]      w;
  logic [15:0]      tagw;
  logic [15:0]      smp;
  logic [2:0]       sx;
  logic [2:0]       didx;
  logic [2:0]       set_sts;
  logic [4:0]       last;
  logic             rise;
  logic             fall;
  logic             hit;
  logic             hs;

  // Bit clock and both serial inputs share one synchroniser so they stay aligned
  ac_link_ctrl_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i  ({bit_clk_i, sdata_in_i}),
    .q_o  (pin_s)
  );

  for (genvar g = 0; g < ac_link_ctrl_pkg::NSTR; g++)
  begin : g_fifo
    ac_link_ctrl_fifo u_fifo (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .push_i (push[g]),
      .data_i (ac_link_ctrl_pkg::RX_MASK[g] ? rx_word : wb_dat_i),
      .pop_i  (pop[g]),
      .data_o (fdout[g]),
      .empty_o(empty[g]),
      .full_o (full[g])
    );
  end

  always_comb
  begin
    d = q;
    push = '0;
    pop = '0;
    acc_hit = '0;
    rx_word = '0;
    set_sts = '0;
    w = '0;
    tagw = '0;
    smp = '0;
    hs = 1'b0;
    sx = ac_link_ctrl_pkg::STR_NONE;
    rise = pin_s[2] & ~q.bck;
    fall = ~pin_s[2] & q.bck;
    last = (q.slot == ac_link_ctrl_pkg::SLOT_TAG) ? ac_link_ctrl_pkg::POS_TAG_LAST : ac_link_ctrl_pkg::POS_LAST;
    hit = wb_cyc_i & wb_stb_i & ~q.ack;
    didx = wb_adr_i[4:2];
    d.bck = pin_s[2];
    d.ack = hit;
    // Link held in reset: park the counters so the first edge opens a frame
    if (!q.ctl[ac_link_ctrl_pkg::CTL_LINK])
    begin
      d.slot = ac_link_ctrl_pkg::SLOT_LAST;
      d.pos = ac_link_ctrl_pkg::POS_LAST;
      d.sync = 1'b0;
      d.sdo = 1'b0;
      d.act = '0;
      d.half = '0;
      d.cmd_frm = 1'b0;
      d.sreq = '0;
    end
    else if (rise)
    begin
      if (q.pos != last)
      begin
        d.pos = q.pos + 5'h01;
        d.txsh = {q.txsh[18:0], 1'b0};
      end
      else
      begin
        d.pos = '0;
        d.slot = (q.slot == ac_link_ctrl_pkg::SLOT_LAST) ? ac_link_ctrl_pkg::SLOT_TAG : q.slot + 4'h1;
        case (d.slot)
          ac_link_ctrl_pkg::SLOT_TAG:
          begin
            if (q.cmd_frm && q.acc_rd)
              d.ast = ac_link_ctrl_pkg::ACC_RX;
            else if (q.cmd_frm)
            begin
              d.ast = ac_link_ctrl_pkg::ACC_IDLE;
              set_sts[ac_link_ctrl_pkg::STS_ACC] = 1'b1;
            end
            d.cmd_frm = (q.ast == ac_link_ctrl_pkg::ACC_PEND);
            if (q.ast == ac_link_ctrl_pkg::ACC_PEND)
              d.ast = ac_link_ctrl_pkg::ACC_TX;
            // Requests are active low and come from the previous frame
            for (int k = 0; k < ac_link_ctrl_pkg::NSTR; k++)
            begin
              d.act[k] = ~ac_link_ctrl_pkg::RX_MASK[k] & q.slt[k] & ~empty[k]
                         & ~q.sreq[ac_link_ctrl_pkg::tx_slot(3'(k))];
            end
            tagw[14] = d.cmd_frm & (q.acc_id == 2'h0);
            tagw[13] = tagw[14] & ~q.acc_rd;
            for (int n = 3; n <= 12; n++)
            begin
              sx = ac_link_ctrl_pkg::tx_map(4'(n));
              if (sx != ac_link_ctrl_pkg::STR_NONE)
                tagw[15 - n] = d.act[sx];
            end
            tagw[15] = (|tagw[14:3]) | d.cmd_frm;
            tagw[1:0] = d.cmd_frm ? q.acc_id : 2'h0;
            w = {tagw, 4'h0};
          end
          ac_link_ctrl_pkg::SLOT_CMD:
          begin
            if (q.cmd_frm)
              w = {q.acc_rd, q.acc_addr, 12'h000};
          end
          ac_link_ctrl_pkg::SLOT_DAT:
          begin
            if (q.cmd_frm && !q.acc_rd)
              w = {q.acc_wdat, 4'h0};
          end
          default:
          begin
            sx = ac_link_ctrl_pkg::tx_map(d.slot);
            if (sx != ac_link_ctrl_pkg::STR_NONE && q.act[sx])
            begin
              // Low half first: left of a pair, or earlier of two mono samples
              smp = q.half[sx] ? fdout[sx][31:16] : fdout[sx][15:0];
              w = {smp, 4'h0};
              d.half[sx] = ~q.half[sx];
              pop[sx] = q.half[sx];
            end
          end
        endcase
        d.txsh = w;
        d.sync = (d.slot == ac_link_ctrl_pkg::SLOT_TAG);
      end
      d.sdo = d.txsh[19];
    end
    else if (fall)
    begin
      w = {q.rxsh[18:0], pin_s[0] | pin_s[1]};
      d.rxsh = w;
      if (q.slot == ac_link_ctrl_pkg::SLOT_TAG && q.pos == 5'h00)
        set_sts[1:0] = pin_s[1:0];
      if (q.pos == last)
      begin
        case (q.slot)
          ac_link_ctrl_pkg::SLOT_TAG:
            d.tagv = w[15:0];
          ac_link_ctrl_pkg::SLOT_CMD:
          begin
            // Request bit 11 belongs to slot 3, bit 2 to slot 12
            for (int n = 3; n <= 12; n++)
              d.sreq[n] = w[14 - n];
            d.st_ok = q.tagv[14] & (w[18:12] == q.acc_addr);
          end
          ac_link_ctrl_pkg::SLOT_DAT:
          begin
            if (q.ast == ac_link_ctrl_pkg::ACC_RX && q.st_ok && q.tagv[13])
            begin
              d.acc_rdat = w[19:4];
              d.ast = ac_link_ctrl_pkg::ACC_IDLE;
              set_sts[ac_link_ctrl_pkg::STS_ACC] = 1'b1;
            end
          end
          default:
          begin
            sx = ac_link_ctrl_pkg::rx_map(q.slot, q.ctl[ac_link_ctrl_pkg::CTL_MIC]);
            smp = w[19:4];
            hs = (sx == ac_link_ctrl_pkg::STR_MDI);
            if (sx != ac_link_ctrl_pkg::STR_NONE && q.tagv[4'hf - q.slot] && q.slt[sx])
            begin
              // A full FIFO drops the word; DMA was too slow
              if (sx == ac_link_ctrl_pkg::STR_REC && q.ctl[ac_link_ctrl_pkg::CTL_MIC])
              begin
                rx_word = {16'h0000, smp};
                push[sx] = ~full[sx];
              end
              // A left slot always restarts the pair, so a mid-frame enable cannot swap halves
              else if (!q.half[sx] || q.slot == 4'h3)
              begin
                d.hold[hs] = smp;
                d.half[sx] = 1'b1;
              end
              else
              begin
                rx_word = {smp, q.hold[hs]};
                push[sx] = ~full[sx];
                d.half[sx] = 1'b0;
              end
            end
          end
        endcase
      end
    end
    if (hit)
    begin
      d.rdat = '0;
      if (wb_adr_i == ac_link_ctrl_pkg::OFF_CTL)
      begin
        d.rdat = q.ctl;
        if (wb_we_i)
          d.ctl = wb_dat_i;
      end
      else if (wb_adr_i == ac_link_ctrl_pkg::OFF_SLT)
      begin
        d.rdat = {25'h0, q.slt};
        if (wb_we_i)
          d.slt = wb_dat_i[6:0];
      end
      else if (wb_adr_i == ac_link_ctrl_pkg::OFF_STS)
      begin
        d.rdat = {29'h0, q.sts};
        if (wb_we_i)
          d.sts = q.sts & ~wb_dat_i[2:0];
      end
      else if (wb_adr_i == ac_link_ctrl_pkg::OFF_MSK)
      begin
        d.rdat = {29'h0, q.msk};
        if (wb_we_i)
          d.msk = wb_dat_i[2:0];
      end
      else if (wb_adr_i == ac_link_ctrl_pkg::OFF_ACC)
      begin
        d.rdat = {q.acc_rd, 5'h00, q.acc_id, 1'b0, q.acc_addr, q.acc_rdat};
        if (wb_we_i)
        begin
          d.acc_rd = wb_dat_i[ac_link_ctrl_pkg::ACC_RD_BIT];
          d.acc_id = wb_dat_i[ac_link_ctrl_pkg::ACC_ID_LSB +: 2];
          d.acc_addr = wb_dat_i[ac_link_ctrl_pkg::ACC_ADDR_LSB +: 7];
          d.acc_wdat = wb_dat_i[15:0];
          d.ast = ac_link_ctrl_pkg::ACC_PEND;
        end
      end
      else if (wb_adr_i[7:5] == ac_link_ctrl_pkg::OFF_DAT[7:5] && didx != ac_link_ctrl_pkg::STR_NONE)
      begin
        // Partial-word accesses are acknowledged but move no data
        if (wb_sel_i == 4'hf)
        begin
          acc_hit[didx] = 1'b1;
          if (ac_link_ctrl_pkg::RX_MASK[didx])
          begin
            d.rdat = fdout[didx];
            pop[didx] = ~wb_we_i;
          end
          else
            push[didx] = wb_we_i;
        end
      end
    end
    d.sts = d.sts | set_sts;  // Hardware set wins over a same-cycle clear
    d.irq = |(d.sts & d.msk);
    for (int k = 0; k < ac_link_ctrl_pkg::NSTR; k++)
    begin
      d.dreq[k] = q.ctl[k] & ~acc_hit[k]
                  & (ac_link_ctrl_pkg::RX_MASK[k] ? ~empty[k] : ~full[k]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign sync_o = q.sync;
  assign sdata_out_o = q.sdo;
  assign link_reset_n_o = q.ctl[ac_link_ctrl_pkg::CTL_LINK];
  assign dma_req_o = q.dreq;
  assign irq_o = q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_ctl;
    hit && wb_we_i && wb_adr_i == ac_link_ctrl_pkg::OFF_CTL;
  endsequence
  sequence s_rd_issue;
    hit && wb_we_i && wb_adr_i == ac_link_ctrl_pkg::OFF_ACC && wb_dat_i[31];
  endsequence

  a_link_reset_pin: assert property (s_wr_ctl |=> link_reset_n_o == $past(wb_dat_i[16]))
    else $error("link reset does not follow enable bit");
  a_sync_frame_start: assert property ($rose(sync_o) |-> q.slot == 4'h0 && q.pos == 5'h00)
    else $error("sync rose away from frame start");
  a_ready_flag_set: assert property (
    q.ctl[16] && fall && q.slot == 4'h0 && q.pos == 5'h00 && pin_s[1] |=> q.sts[1])
    else $error("codec ready not recorded");
  a_irq_mask_gate: assert property (irq_o == |(q.sts & q.msk))
    else $error("interrupt not tied to masked status");
  a_access_done_src: assert property (
    $rose(q.sts[2]) |-> $past(q.ast) == ac_link_ctrl_pkg::ACC_TX || $past(q.ast) == ac_link_ctrl_pkg::ACC_RX)
    else $error("access ready without an access");
  a_read_issue: assert property (s_rd_issue |=> q.ast == ac_link_ctrl_pkg::ACC_PEND && q.acc_rd)
    else $error("read access not started");
  a_write_cmd_data: assert property (
    q.cmd_frm && !q.acc_rd && q.slot == 4'h2 && q.pos == 5'h00
    |-> q.txsh[19:4] == q.acc_wdat && q.txsh[3:0] == 4'h0)
    else $error("write data slot wrong");
  a_slot_gate: assert property ($rose(sync_o) |-> (q.act & ~$past(q.slt)) == 7'h00)
    else $error("disabled stream sent");
  a_dma_drop: assert property (|acc_hit |=> (dma_req_o & $past(acc_hit)) == 7'h00)
    else $error("dma request held after access");
  a_word_access: assert property (
    hit && wb_sel_i != 4'hf |-> (push & ~ac_link_ctrl_pkg::RX_MASK) == 7'h00)
    else $error("partial access moved data");
endmodule
`default_nettype wire

// *** verilog/ac_link_ctrl_fifo.sv ***
// Purpose: Two-word sample FIFO for one stream
// Assumes: Push when full and pop when empty are ignored
// Notes:   Output word is the registered head entry
`timescale 1ns/100ps
`default_nettype none
module ac_link_ctrl_fifo (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic [31:0] data_i,
  input  wire logic        pop_i,
  output logic      [31:0] data_o,
  output logic             empty_o,
  output logic             full_o
);
  typedef struct packed {
    logic [1:0][31:0] mem;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
  } ac_link_ctrl_fifo_s;

  ac_link_ctrl_fifo_s q;
  ac_link_ctrl_fifo_s d;
  logic       do_push;
  logic       do_pop;

  always_comb
  begin
    d = q;
    do_push = push_i & (q.cnt != ac_link_ctrl_pkg::FIFO_DEPTH);
    do_pop = pop_i & (q.cnt != 2'h0);
    if (do_push)
    begin
      d.mem[q.wp] = data_i;
      d.wp = ~q.wp;
    end
    if (do_pop)
      d.rp = ~q.rp;
    d.cnt = q.cnt + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign data_o = q.mem[q.rp];
  assign empty_o = (q.cnt == 2'h0);
  assign full_o = (q.cnt == ac_link_ctrl_pkg::FIFO_DEPTH);
endmodule
`default_nettype wire

// *** verilog/ac_link_ctrl_pkg.sv ***
// Purpose: Shared constants, types and slot decoding for the AC-link controller
// Assumes: Byte addresses on an 8-bit classic Wishbone address
// Notes:   Data slots carry 16-bit samples in the upper bits of 20-bit slots
package ac_link_ctrl_pkg;
  localparam int NSTR = 7;
  localparam logic [7:0] OFF_CTL = 8'h00;
  localparam logic [7:0] OFF_SLT = 8'h04;
  localparam logic [7:0] OFF_STS = 8'h08;
  localparam logic [7:0] OFF_MSK = 8'h0c;
  localparam logic [7:0] OFF_ACC = 8'h10;
  localparam logic [7:0] OFF_DAT = 8'h20;
  localparam int CTL_LINK = 16;
  localparam int CTL_MIC = 17;
  localparam int STS_ACC = 2;
  localparam int ACC_RD_BIT = 31;
  localparam int ACC_ID_LSB = 24;
  localparam int ACC_ADDR_LSB = 16;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [3:0] SLOT_TAG = 4'h0;
  localparam logic [3:0] SLOT_CMD = 4'h1;
  localparam logic [3:0] SLOT_DAT = 4'h2;
  localparam logic [3:0] SLOT_LAST = 4'hc;
  localparam logic [4:0] POS_TAG_LAST = 5'h0f;
  localparam logic [4:0] POS_LAST = 5'h13;
  localparam logic [2:0] STR_PCM = 3'h0;
  localparam logic [2:0] STR_SUR = 3'h1;
  localparam logic [2:0] STR_CEN = 3'h2;
  localparam logic [2:0] STR_LFE = 3'h3;
  localparam logic [2:0] STR_REC = 3'h4;
  localparam logic [2:0] STR_MDO = 3'h5;
  localparam logic [2:0] STR_MDI = 3'h6;
  localparam logic [2:0] STR_NONE = 3'h7;
  localparam logic [6:0] RX_MASK = 7'h50;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [1:0] {ACC_IDLE, ACC_PEND, ACC_TX, ACC_RX} ac_link_ctrl_acc_e;

  function automatic logic [2:0] tx_map(input logic [3:0] s);
    case (s)
      4'h3, 4'h4: tx_map = STR_PCM;
      4'h5: tx_map = STR_MDO;
      4'h6: tx_map = STR_CEN;
      4'h7, 4'h8: tx_map = STR_SUR;
      4'h9: tx_map = STR_LFE;
      default: tx_map = STR_NONE;
    endcase
  endfunction

  function automatic logic [3:0] tx_slot(input logic [2:0] k);
    case (k)
      STR_SUR: tx_slot = 4'h7;
      STR_CEN: tx_slot = 4'h6;
      STR_LFE: tx_slot = 4'h9;
      STR_MDO: tx_slot = 4'h5;
      default: tx_slot = 4'h3;
    endcase
  endfunction

  function automatic logic [2:0] rx_map(input logic [3:0] s, input logic mic);
    case (s)
      4'h3, 4'h4: rx_map = mic ? STR_NONE : STR_REC;
      4'h5: rx_map = STR_MDI;
      4'h6: rx_map = mic ? STR_REC : STR_NONE;
      default: rx_map = STR_NONE;
    endcase
  endfunction
endpackage

// *** verilog/ac_link_ctrl_sync.sv ***
// Purpose: Two-stage synchroniser for link pins
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module ac_link_ctrl_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ac_link_ctrl_sync_s;

  ac_link_ctrl_sync_s q;
  ac_link_ctrl_sync_s d;

  always_comb
  begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign q_o = q.s2;
endmodule
`default_nettype wire
